//--- hw/pesu_top.sv
// per-port event status, upper byte: sticky flags, force, irq, port-write
//
// How it works
// - illegal transfer flag on reserved tt/unmapped
// - illegal flag sticks until written one or forced zero
// - enabled illegal flag raises irq and port-write
// - illegal port-write goes out immediately
// - illegal event also pulses error-detect bit zero
// - summary flag set on error, held while pending
// - summary irq only while its enable set
// - retry flag on threshold reach, irq, port-write
// - retry count never sets the retry flag with zero threshold
// - retry/timeout clear by one or detect clear
// - outbound flag when output depth reaches threshold
// - outbound write one clears flag and counter
// - inbound flag when input depth reaches threshold
// - inbound write one clears flag and counter
// - reorder flag when reorder count reaches threshold
// - reorder write one clears flag and counter
// - queue and reorder irqs gated by enables
// - timeout flag on fabric delivery timeout
// - force write zero clears matching status bit
// - force write one sets flag; reads zero
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// sticky flag cell: set wins over clear
// ----------------------------------------------------------------
module pesu_flag (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control
    input wire logic set,
    input wire logic clr,
    // state
    output logic q
);

    // sticky bit, a set in the clearing cycle is kept
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            q <= 1'b0;
        end else begin
            q <= set | (q & ~clr);
        end
    end

endmodule : pesu_flag

// ----------------------------------------------------------------
// top level
// ----------------------------------------------------------------
module pesu_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [pesu_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pesu_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pesu_pkg::DATA_W-1:0] reg_rdata,
    // received packet check
    input wire logic pkt_valid,
    input wire logic pkt_reserved_tt,
    input wire logic pkt_maint_hop0,
    input wire logic pkt_dest_unmapped,
    // port error sources
    input wire logic port_error_event,
    input wire logic port_error_pending,
    input wire logic detect_all_cleared,
    // counts and thresholds
    input wire logic [pesu_pkg::CNT_W-1:0] retry_count,
    input wire logic [pesu_pkg::CNT_W-1:0] retry_threshold,
    input wire logic [pesu_pkg::CNT_W-1:0] outq_depth_count,
    input wire logic [pesu_pkg::CNT_W-1:0] outq_threshold,
    input wire logic [pesu_pkg::CNT_W-1:0] inq_depth_count,
    input wire logic [pesu_pkg::CNT_W-1:0] inq_threshold,
    input wire logic [pesu_pkg::CNT_W-1:0] reorder_count,
    input wire logic [pesu_pkg::CNT_W-1:0] reorder_threshold,
    // fabric
    input wire logic fabric_timeout,
    // enables from the control register
    input wire logic illegal_transfer_enable,
    input wire logic summary_enable,
    input wire logic retry_enable,
    input wire logic retry_pw_enable,
    input wire logic outq_enable,
    input wire logic inq_enable,
    input wire logic reorder_enable,
    input wire logic timeout_enable,
    // event outputs
    output logic port_irq,
    output logic port_write_req,
    output logic detect_illegal_set,
    output logic outbound_congestion_counter_clr,
    output logic inbound_congestion_counter_clr,
    output logic reorder_event_counter_clr
);

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic hit_status;       // address selects status register
    logic hit_force;        // address selects force register
    logic wr_status;        // write to status register
    logic wr_force;         // write to force register

    assign hit_status = (reg_addr == pesu_pkg::OFF_STATUS);
    assign hit_force = (reg_addr == pesu_pkg::OFF_FORCE);
    assign wr_status = reg_wr & hit_status;
    assign wr_force = reg_wr & hit_force;

    // ------------------------------------------------------------
    // per-bit write effects
    // ------------------------------------------------------------
    logic [pesu_pkg::DATA_W-1:0] w1c;     // status write of one clears
    logic [pesu_pkg::DATA_W-1:0] fset;    // force write of one sets
    logic [pesu_pkg::DATA_W-1:0] fclr;    // force write of zero clears

    assign w1c = wr_status ? reg_wdata : pesu_pkg::READ_ZERO;
    assign fset = wr_force ? reg_wdata : pesu_pkg::READ_ZERO;
    assign fclr = wr_force ? ~reg_wdata : pesu_pkg::READ_ZERO;

    // ------------------------------------------------------------
    // hardware event detection
    // ------------------------------------------------------------
    logic ev_illegal;       // illegal transfer seen
    logic ev_retry;         // retry count reached limit
    logic ev_outq;          // output depth reached threshold
    logic ev_inq;           // input depth reached threshold
    logic ev_reorder;       // reorder count reached threshold

    // reserved tt except maintenance with hop zero, or unmapped id
    assign ev_illegal = pkt_valid &
        ((pkt_reserved_tt & ~pkt_maint_hop0) | pkt_dest_unmapped);

    // zero threshold switches the retry event off
    assign ev_retry = (retry_threshold != pesu_pkg::THRESH_OFF) &
        (retry_count >= retry_threshold);

    assign ev_outq = (outq_threshold != pesu_pkg::THRESH_OFF) &
        (outq_depth_count >= outq_threshold);
    assign ev_inq = (inq_threshold != pesu_pkg::THRESH_OFF) &
        (inq_depth_count >= inq_threshold);
    assign ev_reorder = (reorder_threshold != pesu_pkg::THRESH_OFF) &
        (reorder_count >= reorder_threshold);

    // ------------------------------------------------------------
    // set and clear terms of each flag
    // ------------------------------------------------------------
    logic set_illegal;
    logic set_retry;
    logic set_outq;
    logic set_inq;
    logic set_reorder;
    logic set_timeout;
    logic clr_illegal;
    logic clr_retry;
    logic clr_outq;
    logic clr_inq;
    logic clr_reorder;
    logic clr_timeout;

    // hardware event or forced from the force register
    assign set_illegal = ev_illegal | fset[pesu_pkg::BIT_ILLEGAL];
    assign set_retry = ev_retry | fset[pesu_pkg::BIT_RETRY];
    assign set_outq = ev_outq | fset[pesu_pkg::BIT_OUTQ];
    assign set_inq = ev_inq | fset[pesu_pkg::BIT_INQ];
    assign set_reorder = ev_reorder | fset[pesu_pkg::BIT_REORDER];
    assign set_timeout = fabric_timeout | fset[pesu_pkg::BIT_TIMEOUT];

    // only a write of one or a force of zero clears it
    assign clr_illegal = w1c[pesu_pkg::BIT_ILLEGAL] |
        fclr[pesu_pkg::BIT_ILLEGAL];
    // detect register wipe also clears these two
    assign clr_retry = w1c[pesu_pkg::BIT_RETRY] |
        fclr[pesu_pkg::BIT_RETRY] | detect_all_cleared;
    assign clr_timeout = w1c[pesu_pkg::BIT_TIMEOUT] |
        fclr[pesu_pkg::BIT_TIMEOUT] | detect_all_cleared;
    assign clr_outq = w1c[pesu_pkg::BIT_OUTQ] | fclr[pesu_pkg::BIT_OUTQ];
    assign clr_inq = w1c[pesu_pkg::BIT_INQ] | fclr[pesu_pkg::BIT_INQ];
    assign clr_reorder = w1c[pesu_pkg::BIT_REORDER] |
        fclr[pesu_pkg::BIT_REORDER];

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    logic illegal_transfer_flag;
    logic error_summary_flag;
    logic retry_limit_flag;
    logic outbound_queue_flag;
    logic inbound_queue_flag;
    logic reorder_limit_flag;
    logic fabric_timeout_flag;

    // illegal transfer
    pesu_flag u_illegal (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(set_illegal),
        .clr(clr_illegal),
        .q(illegal_transfer_flag)
    );

    // retry limit
    pesu_flag u_retry (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(set_retry),
        .clr(clr_retry),
        .q(retry_limit_flag)
    );

    // outbound queue depth
    pesu_flag u_outq (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(set_outq),
        .clr(clr_outq),
        .q(outbound_queue_flag)
    );

    // inbound queue depth
    pesu_flag u_inq (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(set_inq),
        .clr(clr_inq),
        .q(inbound_queue_flag)
    );

    // reorder limit
    pesu_flag u_reorder (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(set_reorder),
        .clr(clr_reorder),
        .q(reorder_limit_flag)
    );

    // fabric delivery timeout
    pesu_flag u_timeout (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(set_timeout),
        .clr(clr_timeout),
        .q(fabric_timeout_flag)
    );

    // error summary: read only, held while any source is pending
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            error_summary_flag <= 1'b0;
        end else begin
            error_summary_flag <= port_error_event |
                (error_summary_flag & port_error_pending);
        end
    end

    // ------------------------------------------------------------
    // status word as software sees it
    // ------------------------------------------------------------
    logic [pesu_pkg::DATA_W-1:0] status_word;

    // unlisted and reserved bits read as zero
    always_comb begin
        status_word = pesu_pkg::RST_STATUS;
        status_word[pesu_pkg::BIT_ILLEGAL] = illegal_transfer_flag;
        status_word[pesu_pkg::BIT_SUMMARY] = error_summary_flag;
        status_word[pesu_pkg::BIT_RETRY] = retry_limit_flag;
        status_word[pesu_pkg::BIT_OUTQ] = outbound_queue_flag;
        status_word[pesu_pkg::BIT_INQ] = inbound_queue_flag;
        status_word[pesu_pkg::BIT_REORDER] = reorder_limit_flag;
        status_word[pesu_pkg::BIT_TIMEOUT] = fabric_timeout_flag;
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    // force register and unmapped addresses read as zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata <= pesu_pkg::READ_ZERO;
        end else if (reg_rd && hit_status) begin
            reg_rdata <= status_word;
        end else begin
            reg_rdata <= pesu_pkg::READ_ZERO;
        end
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    logic next_irq;

    // each flag gated by its own enable, then ORed
    always_comb begin
        next_irq = (illegal_transfer_flag & illegal_transfer_enable) |
            (error_summary_flag & summary_enable) |
            (retry_limit_flag & retry_enable) |
            (outbound_queue_flag & outq_enable) |
            (inbound_queue_flag & inq_enable) |
            (reorder_limit_flag & reorder_enable) |
            (fabric_timeout_flag & timeout_enable);
    end

    // registered level, follows flags one cycle later
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            port_irq <= 1'b0;
        end else begin
            port_irq <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // port-write request
    // ------------------------------------------------------------
    logic rise_illegal;     // illegal flag about to go high
    logic rise_retry;       // retry flag about to go high

    assign rise_illegal = set_illegal & ~illegal_transfer_flag;
    assign rise_retry = set_retry & ~retry_limit_flag;

    // no wait on any error-rate threshold for illegal transfers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            port_write_req <= 1'b0;
        end else begin
            port_write_req <= (rise_illegal & illegal_transfer_enable) |
                (rise_retry & retry_pw_enable);
        end
    end

    // ------------------------------------------------------------
    // error-detect record of illegal transfers
    // ------------------------------------------------------------
    // one pulse per illegal packet, forced ones included
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            detect_illegal_set <= 1'b0;
        end else begin
            detect_illegal_set <= set_illegal;
        end
    end

    // ------------------------------------------------------------
    // congestion counter clears
    // ------------------------------------------------------------
    // a status write of one resets the matching external counter
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            outbound_congestion_counter_clr <= 1'b0;
            inbound_congestion_counter_clr <= 1'b0;
            reorder_event_counter_clr <= 1'b0;
        end else begin
            outbound_congestion_counter_clr <= w1c[pesu_pkg::BIT_OUTQ];
            inbound_congestion_counter_clr <= w1c[pesu_pkg::BIT_INQ];
            reorder_event_counter_clr <= w1c[pesu_pkg::BIT_REORDER];
        end
    end

endmodule : pesu_top

`default_nettype wire

//--- include/pesu_pkg.sv
// constants for the per-port event status (upper byte) block
`default_nettype none

package pesu_pkg;

    // ------------------------------------------------------------
    // register bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;             // byte address width
    localparam int DATA_W = 32;             // register data width
    localparam int CNT_W = 16;              // depth / retry count width

    // ------------------------------------------------------------
    // register byte offsets (port 0 instance)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_STATUS = 20'h13018;   // event status
    localparam logic [ADDR_W-1:0] OFF_FORCE = 20'h1301c;    // event force

    // ------------------------------------------------------------
    // field positions inside both registers
    // ------------------------------------------------------------
    localparam int BIT_ILLEGAL = 24;        // illegal transfer
    localparam int BIT_SUMMARY = 25;        // error summary, read only
    localparam int BIT_RETRY = 26;          // retry limit
    localparam int BIT_OUTQ = 27;           // outbound queue depth
    localparam int BIT_INQ = 28;            // inbound queue depth
    localparam int BIT_REORDER = 29;        // reorder limit
    localparam int BIT_TIMEOUT = 31;        // fabric delivery timeout

    // ------------------------------------------------------------
    // reset and constant values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_STATUS = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] THRESH_OFF = 16'h0000;   // threshold off

endpackage : pesu_pkg

`default_nettype wire

//--- sim/pesu_assertions.sv
// checker for the event status block: relations between its ports
`timescale 1ns/1ns
`default_nettype none

module pesu_assertions (
    // clock, reset and register port
    input wire logic ref_clk, resetn, reg_wr, reg_rd,
    input wire logic [pesu_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pesu_pkg::DATA_W-1:0] reg_wdata, reg_rdata,
    // packet check and outbound depth
    input wire logic pkt_valid, pkt_reserved_tt, pkt_maint_hop0,
    input wire logic pkt_dest_unmapped,
    input wire logic [pesu_pkg::CNT_W-1:0] outq_depth_count, outq_threshold,
    // enables
    input wire logic illegal_transfer_enable, summary_enable, retry_enable,
    input wire logic retry_pw_enable, outq_enable, inq_enable,
    input wire logic reorder_enable, timeout_enable,
    // event outputs
    input wire logic port_irq, port_write_req, detect_illegal_set,
    input wire logic outbound_congestion_counter_clr,
    input wire logic inbound_congestion_counter_clr,
    input wire logic reorder_event_counter_clr
);
    // ------------------------------------------------------------
    // helper terms
    // ------------------------------------------------------------
    logic ill_cause; // illegal packet seen this cycle
    logic st_wr; // write to the status register
    logic any_en; // some flag enable is on
    assign ill_cause = pkt_valid && (pkt_dest_unmapped ||
        (pkt_reserved_tt && !pkt_maint_hop0));
    assign st_wr = reg_wr && reg_addr == pesu_pkg::OFF_STATUS;
    assign any_en = illegal_transfer_enable || summary_enable ||
        retry_enable || outq_enable || inq_enable || reorder_enable ||
        timeout_enable;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_ill_detect;
        ill_cause |=> detect_illegal_set;
    endproperty
    a_ill_detect: assert property (p_ill_detect)
        else $error("illegal packet gave no detect pulse");
    property p_detect_cause;
        detect_illegal_set |-> $past(ill_cause) || $past(reg_wr);
    endproperty
    a_detect_cause: assert property (p_detect_cause)
        else $error("detect pulse without cause");
    property p_irq_ill;
        ill_cause && illegal_transfer_enable ##1 illegal_transfer_enable
            |=> port_irq;
    endproperty
    a_irq_ill: assert property (p_irq_ill)
        else $error("enabled illegal flag gave no irq");
    property p_pw_cause;
        port_write_req |-> $past(illegal_transfer_enable || retry_pw_enable);
    endproperty
    a_pw_cause: assert property (p_pw_cause)
        else $error("port-write while disabled");
    property p_irq_outq;
        outq_depth_count >= outq_threshold && outq_threshold != 16'h0000 &&
            outq_enable ##1 outq_enable |=> port_irq;
    endproperty
    a_irq_outq: assert property (p_irq_outq)
        else $error("outbound depth gave no irq");
    property p_irq_off;
        !any_en |=> !port_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq with all enables off");
    property p_outq_clr;
        st_wr && reg_wdata[pesu_pkg::BIT_OUTQ] |=>
            outbound_congestion_counter_clr;
    endproperty
    a_outq_clr: assert property (p_outq_clr)
        else $error("no outbound counter clear");
    property p_inq_clr;
        inbound_congestion_counter_clr |->
            $past(st_wr && reg_wdata[pesu_pkg::BIT_INQ]);
    endproperty
    a_inq_clr: assert property (p_inq_clr)
        else $error("inbound counter clear without write");
    property p_rdr_clr;
        st_wr && reg_wdata[pesu_pkg::BIT_REORDER] |=>
            reorder_event_counter_clr;
    endproperty
    a_rdr_clr: assert property (p_rdr_clr)
        else $error("no reorder counter clear");
    property p_rd_force;
        reg_rd && reg_addr == pesu_pkg::OFF_FORCE |=>
            reg_rdata == pesu_pkg::READ_ZERO;
    endproperty
    a_rd_force: assert property (p_rd_force)
        else $error("force register read not zero");
    property p_rd_res;
        reg_rd |=> reg_rdata[23:0] == 24'h000000 && !reg_rdata[30];
    endproperty
    a_rd_res: assert property (p_rd_res)
        else $error("reserved bits read nonzero");
endmodule : pesu_assertions

bind pesu_top pesu_assertions u_chk (.ref_clk(ref_clk), .resetn(resetn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
    .pkt_reserved_tt(pkt_reserved_tt), .pkt_maint_hop0(pkt_maint_hop0),
    .pkt_dest_unmapped(pkt_dest_unmapped),
    .outq_depth_count(outq_depth_count), .outq_threshold(outq_threshold),
    .illegal_transfer_enable(illegal_transfer_enable),
    .summary_enable(summary_enable), .retry_enable(retry_enable),
    .retry_pw_enable(retry_pw_enable), .outq_enable(outq_enable),
    .inq_enable(inq_enable), .reorder_enable(reorder_enable),
    .timeout_enable(timeout_enable), .port_irq(port_irq),
    .port_write_req(port_write_req), .detect_illegal_set(detect_illegal_set),
    .outbound_congestion_counter_clr(outbound_congestion_counter_clr),
    .inbound_congestion_counter_clr(inbound_congestion_counter_clr),
    .reorder_event_counter_clr(reorder_event_counter_clr));

`default_nettype wire

//--- sim/pesu_top_tb_top.sv
// testbench for the event status block
`timescale 1ns/1ns
`default_nettype none

module pesu_top_tb_top;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [pesu_pkg::ADDR_W-1:0] reg_addr = '0;
    logic [pesu_pkg::DATA_W-1:0] reg_wdata = '0;
    logic [pesu_pkg::DATA_W-1:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pkt_valid = 1'b0;
    logic [2:0] pkt = 3'h0; // reserved tt, maint hop0, unmapped
    logic [2:0] err = 3'h0; // event, pending, all cleared
    logic fabric_timeout = 1'b0;
    logic [pesu_pkg::CNT_W-1:0] cnt [4] = '{default: 16'h0000};
    logic [pesu_pkg::CNT_W-1:0] thr [4] = '{default: 16'h0005};
    logic [7:0] en = 8'h00; // one bit per enable input
    logic port_irq, port_write_req, detect_illegal_set;
    logic ob_clr, ib_clr, rdr_clr; // counter clear pulses
    logic [31:0] v; // read value
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    localparam logic [19:0] sts = pesu_pkg::OFF_STATUS;
    localparam logic [19:0] frc = pesu_pkg::OFF_FORCE;

    pesu_top uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
        .pkt_reserved_tt(pkt[2]), .pkt_maint_hop0(pkt[1]),
        .pkt_dest_unmapped(pkt[0]), .port_error_event(err[2]),
        .port_error_pending(err[1]), .detect_all_cleared(err[0]),
        .retry_count(cnt[0]), .retry_threshold(thr[0]),
        .outq_depth_count(cnt[1]), .outq_threshold(thr[1]),
        .inq_depth_count(cnt[2]), .inq_threshold(thr[2]),
        .reorder_count(cnt[3]), .reorder_threshold(thr[3]),
        .fabric_timeout(fabric_timeout), .illegal_transfer_enable(en[0]),
        .summary_enable(en[1]), .retry_enable(en[2]),
        .retry_pw_enable(en[7]), .outq_enable(en[3]), .inq_enable(en[4]),
        .reorder_enable(en[5]), .timeout_enable(en[6]),
        .port_irq(port_irq), .port_write_req(port_write_req),
        .detect_illegal_set(detect_illegal_set),
        .outbound_congestion_counter_clr(ob_clr),
        .inbound_congestion_counter_clr(ib_clr),
        .reorder_event_counter_clr(rdr_clr));

    // ------------------------------------------------------------
    // clock, timeout and tasks
    // ------------------------------------------------------------
    always #2 ref_clk = ~ref_clk;

    // cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // compare a register word
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk

    // compare a single output bit
    task chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk1

    // one-cycle register write
    task wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // one-cycle register read, compared with expected word
    task rd(input logic [19:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // one received packet with the given check bits
    task pk(input logic [2:0] p);
        @(posedge ref_clk);
        pkt_valid <= 1'b1;
        pkt <= p;
        @(posedge ref_clk);
        pkt_valid <= 1'b0;
        pkt <= 3'h0;
        #1;
    endtask : pk

    // one cycle with a count at its threshold
    task hit(input int i);
        @(posedge ref_clk);
        cnt[i] <= 16'h0005;
        @(posedge ref_clk);
        cnt[i] <= 16'h0000;
        #1;
    endtask : hit

    // one-cycle pulse on the error sources, pending level given
    task ep(input logic [2:0] e, input logic pend);
        @(posedge ref_clk);
        err <= e;
        @(posedge ref_clk);
        err <= {1'b0, pend, 1'b0};
    endtask : ep

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(sts, pesu_pkg::RST_STATUS);
        rd(20'h13020, 32'h0); // unmapped place
        en <= 8'h01;
        pk(3'h1); // unmapped destination
        chk1(port_write_req, 1'b1);
        chk1(detect_illegal_set, 1'b1);
        @(posedge ref_clk);
        #1;
        chk1(port_irq, 1'b1);
        wr(sts, 32'h7e00_0000);
        rd(sts, 32'h0100_0000);
        wr(sts, 32'h0100_0000);
        rd(sts, 32'h0);
        chk1(port_irq, 1'b0);
        pk(3'h6); // reserved tt on maintenance hop zero
        chk1(detect_illegal_set, 1'b0);
        pk(3'h4); // reserved tt elsewhere
        rd(sts, 32'h0100_0000);
        wr(sts, 32'h0100_0000);
        // summary flag holds while a source is pending
        en <= 8'h02;
        ep(3'h6, 1'b1);
        wr(sts, 32'h0200_0000);
        rd(sts, 32'h0200_0000);
        chk1(port_irq, 1'b1);
        en <= 8'h00;
        @(posedge ref_clk);
        #1;
        chk1(port_irq, 1'b0);
        ep(3'h0, 1'b0);
        rd(sts, 32'h0);
        // retry, outbound, inbound, reorder thresholds
        for (int i = 0; i < 4; i++) begin
            en <= (i == 0) ? 8'h84 : 8'h04 << i;
            hit(i);
            chk1(port_write_req, i == 0);
            rd(sts, 32'h1 << (26 + i));
            chk1(port_irq, 1'b1);
            wr(sts, 32'h1 << (26 + i));
            chk1(ob_clr, i == 1);
            chk1(ib_clr, i == 2);
            chk1(rdr_clr, i == 3);
            rd(sts, 32'h0);
        end
        en <= 8'h00;
        thr <= '{default: pesu_pkg::THRESH_OFF};
        for (int i = 0; i < 4; i++) begin
            hit(i);
        end
        rd(sts, 32'h0);
        thr <= '{default: 16'h0005};
        // fabric timeout, cleared with retry by detect clear
        @(posedge ref_clk);
        fabric_timeout <= 1'b1;
        @(posedge ref_clk);
        fabric_timeout <= 1'b0;
        hit(0);
        rd(sts, 32'h8400_0000);
        ep(3'h1, 1'b0);
        rd(sts, 32'h0);
        // force register sets, clears and reads zero
        wr(frc, 32'hffff_ffff);
        rd(sts, 32'hbd00_0000);
        rd(frc, pesu_pkg::READ_ZERO);
        chk1(port_irq, 1'b0);
        for (int k = 0; k < 7; k++) begin
            en <= (k == 1) ? 8'h01 : 8'h01 << k;
            @(posedge ref_clk);
            @(posedge ref_clk);
            #1;
            chk1(port_irq, 1'b1);
        end
        wr(sts, 32'h8000_0000);
        rd(sts, 32'h3d00_0000);
        wr(frc, 32'h0800_0000);
        rd(sts, 32'h0800_0000);
        wr(frc, 32'h0);
        wr(20'h13020, 32'hffff_ffff); // unmapped write ignored
        rd(sts, 32'h0);
        end_of_test();
    end
endmodule : pesu_top_tb_top

`default_nettype wire
